// >>> rtl/rtu_scan_pkg.sv
// constants shared by the scan responder and its transmit queue
// assumes a framed 32-bit message link and a 250 MHz system clock
// Behaviour
// - never transmit unprompted; reply only to a request addressed to us
// - gather and store status and data whenever not exchanging messages
// - keep current status, unreported changes and data ready in memory
// - a data reply is 1 to 8 messages, 24 to 192 payload bits
// - ordinary data replies carry no status information
// - any status input change sets one common change flag
// - while the change flag is set, mark the first data message function field
// - always send every requested data message, flag or not
// - every message is two 12-bit groups plus an 8-bit check code
// - accept own 3-bit address and the four common addresses; the code drops common-address requests like foreign ones
package rtu_scan_pkg;

  // ==========================================================
  // message layout
  localparam int MSG_W     = 32;
  localparam int GRP_W     = 12;
  localparam int CHK_W     = 8;
  localparam int PAY_W     = 24;
  localparam int GRP2_LSB  = 12;
  localparam int CHK_LSB   = 24;
  localparam int ADDR_LSB  = 0;
  localparam int ADDR_W    = 3;
  localparam int SUB_LSB   = 3;
  localparam int SUB_W     = 3;
  localparam int CLASS_LSB = 6;
  localparam int CLASS_W   = 3;
  localparam int FUNC_LSB  = 9;
  localparam int FUNC_W    = 3;
  localparam int START_LSB = 12;
  localparam int START_W   = 4;
  localparam int COUNT_LSB = 16;
  localparam int COUNT_W   = 3;
  localparam int CNT_W     = 4;

  // ==========================================================
  // codes and limits
  localparam logic [ADDR_W-1:0]  COMMON_ADDR_MAX = 3'h3;
  localparam logic [CLASS_W-1:0] CLASS_READ      = 3'h4;
  localparam logic [FUNC_W-1:0]  FC_DATA         = 3'h0;
  localparam logic [FUNC_W-1:0]  FC_STATUS       = 3'h1;
  localparam logic [FUNC_W-1:0]  FC_DATA_COS     = 3'h2;
  localparam logic [FUNC_W-1:0]  FC_STATUS_REPLY = 3'h3;
  localparam logic [CNT_W-1:0]   MAX_MSGS        = 4'h8;
  localparam logic [CHK_W-1:0]   CHK_POLY        = 8'h07;
  localparam logic [CHK_W-1:0]   CHK_INIT        = 8'h00;

  // ==========================================================
  // reset values and sizes
  localparam int FIFO_DEPTH   = 16;
  localparam int SYNC_STAGES  = 3;
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REPLY,
    ST_DRAIN
  } scan_state_type;

endpackage

// >>> rtl/rtu_scan_responder.sv
// remote station responder for the polled data scan
// assumes a framer hands complete 32-bit messages in and takes them out
// assumes status contacts and address straps are raw, unsynchronised pins
// assumes converter results arrive on this clock, one reading per pulse
// assumes the master waits for each reply before its next request
`timescale 1ns/10ps
`default_nettype none
module rtu_scan_responder
  import rtu_scan_pkg::*;
#(
  parameter int DATA_WORDS    = 16,
  parameter int STATUS_BLOCKS = 2
) (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            reset,
  // station address straps
  input  wire logic [rtu_scan_pkg::ADDR_W-1:0] station_addr,
  // received messages
  input  wire logic                            rx_valid,
  input  wire logic [rtu_scan_pkg::MSG_W-1:0]  rx_word,
  // transmitted messages
  output logic                                 tx_valid,
  input  wire logic                            tx_ready,
  output logic [rtu_scan_pkg::MSG_W-1:0]       tx_word,
  // acquisition side
  input  wire logic [STATUS_BLOCKS*12-1:0]     status_in,
  input  wire logic                            sample_valid,
  input  wire logic [$clog2(DATA_WORDS)-1:0]   sample_idx,
  input  wire logic [rtu_scan_pkg::GRP_W-1:0]  sample_value,
  output logic                                 acq_enable,
  // station state
  output logic                                 cos_flag,
  output logic                                 busy,
  output logic                                 check_error
);
  import rtu_scan_pkg::*;

  localparam int IDX_W    = $clog2(DATA_WORDS);
  localparam int STATUS_W = STATUS_BLOCKS * GRP_W;
  localparam int SYNC_W   = STATUS_W + ADDR_W;

  // ==========================================================
  // check code
  // one code guards both directions: a request whose code disagrees is
  // dropped, and every reply word carries a code of its own, msb first
  // over the 24 payload bits
  function automatic logic [CHK_W-1:0] chk8(input logic [PAY_W-1:0] d);
    logic [CHK_W-1:0] c;
    logic             fb;
    c = CHK_INIT;
    for (int i = PAY_W - 1; i >= 0; i--) begin
      fb = c[CHK_W-1] ^ d[i];
      c  = {c[CHK_W-2:0], 1'b0};
      if (fb) begin
        c = c ^ CHK_POLY;
      end
    end
    return c;
  endfunction

  // ==========================================================
  // state
  // sequencer
  scan_state_type          st_q;
  scan_state_type          st_d;
  // pin synchroniser and its filtered copy
  logic [SYNC_W-1:0]       sync1_q;
  logic [SYNC_W-1:0]       sync2_q;
  logic [SYNC_W-1:0]       sync3_q;
  logic [SYNC_W-1:0]       filt_q;
  // status, change memory and common flag
  logic [STATUS_W-1:0]     cur_q;
  logic [STATUS_W-1:0]     chg_q;
  logic [STATUS_W-1:0]     chg_d;
  logic                    cos_q;
  logic                    cos_d;
  // converter readings
  logic [GRP_W-1:0]        data_q [DATA_WORDS];
  // request held for the whole reply
  logic                    is_status_q;
  logic [SUB_W-1:0]        sub_q;
  logic [IDX_W-1:0]        start_q;
  logic [CNT_W-1:0]        msg_q;
  logic [CNT_W-1:0]        total_q;
  // registered flags
  logic                    acq_q;
  logic                    busy_q;
  logic                    chk_err_q;
  // queue handshake
  wire                     fifo_ready;
  wire                     fifo_empty;

  // ==========================================================
  // request decode
  wire [ADDR_W-1:0]    own_addr  = filt_q[STATUS_W +: ADDR_W];
  wire [ADDR_W-1:0]    rx_addr   = rx_word[ADDR_LSB +: ADDR_W];
  wire [SUB_W-1:0]     rx_sub    = rx_word[SUB_LSB +: SUB_W];
  wire [CLASS_W-1:0]   rx_class  = rx_word[CLASS_LSB +: CLASS_W];
  wire [FUNC_W-1:0]    rx_func   = rx_word[FUNC_LSB +: FUNC_W];
  wire [START_W-1:0]   rx_start  = rx_word[START_LSB +: START_W];
  wire [COUNT_W-1:0]   rx_count  = rx_word[COUNT_LSB +: COUNT_W];
  wire                 rx_chk_ok =
    chk8(rx_word[PAY_W-1:0]) == rx_word[CHK_LSB +: CHK_W];
  wire                 addr_own  = rx_addr == own_addr;
  wire                 addr_comm = rx_addr <= COMMON_ADDR_MAX;
  wire                 is_read   = rx_class == CLASS_READ;
  wire                 want_data = rx_func == FC_DATA;
  wire                 want_stat = rx_func == FC_STATUS;
  wire                 idle      = st_q == ST_IDLE;
  // common addresses are dropped like foreign ones and never answered, so stations that
  // hear one broadcast cannot talk over each other on the shared link;
  // the idle term makes a request that arrives mid-reply simply vanish
  // only a valid read aimed at this station starts a reply
  wire                 take      = rx_valid && idle && rx_chk_ok &&
                                   addr_own && !addr_comm && is_read &&
                                   (want_data || want_stat);

  // ==========================================================
  // status change detection on filtered inputs
  // changes are looked for only while idle; a contact that moves during a
  // reply is caught on the first idle cycle, as cur_q is frozen till then
  // and still holds the status sampled on the last idle cycle
  wire [STATUS_W-1:0]  filt_sts  = filt_q[STATUS_W-1:0];
  wire [STATUS_W-1:0]  diff      = idle ? (filt_sts ^ cur_q) : '0;
  wire                 clr_chg   = (st_q == ST_DRAIN) && is_status_q &&
                                   fifo_empty;

  // ==========================================================
  // reply message assembly
  // message k carries readings start+2k-1 and start+2k; the index wraps
  // at the top of the store, so a request may run past the last word;
  // status replies walk the blocks instead, status low and changes high
  wire [CNT_W-1:0]     blk       = msg_q - CNT_W'(1);
  wire [IDX_W-1:0]     idx_a     = start_q + IDX_W'({msg_q, 1'b0} - 5'h01);
  wire [IDX_W-1:0]     idx_b     = start_q + IDX_W'({msg_q, 1'b0});
  wire [FUNC_W-1:0]    hdr_fc    = is_status_q ? FC_STATUS_REPLY :
                                   (cos_q ? FC_DATA_COS : FC_DATA);
  wire [GRP_W-1:0]     hdr       = {hdr_fc, CLASS_READ, sub_q, own_addr};
  wire [GRP_W-1:0]     stat_g1   = cur_q[blk*GRP_W +: GRP_W];
  wire [GRP_W-1:0]     stat_g2   = chg_q[blk*GRP_W +: GRP_W];
  wire                 first     = msg_q == CNT_RESET;
  // data replies hold stored readings only, never status
  wire [GRP_W-1:0]     g1        = first ? hdr :
                                   (is_status_q ? stat_g1 : data_q[idx_a]);
  wire [GRP_W-1:0]     g2        = first ?
                                   (is_status_q ? GRP_W'(STATUS_BLOCKS) :
                                    data_q[start_q]) :
                                   (is_status_q ? stat_g2 : data_q[idx_b]);
  wire [PAY_W-1:0]     pay       = {g2, g1};
  wire [MSG_W-1:0]     msg_word  = {chk8(pay), pay};
  wire                 push      = (st_q == ST_REPLY) && fifo_ready;
  wire                 last      = msg_q == total_q;

  // ==========================================================
  // outgoing queue, stalls reply assembly when full
  // sixteen words plus the output stage hold a whole reply, so assembly
  // never waits on a slow master; the ready path is kept as a guard
  // should the queue ever be built shallower
  word_fifo #(
    .WIDTH (MSG_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (msg_word),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_word),
    .empty     (fifo_empty)
  );

  // ==========================================================
  // pin synchroniser, change accepted once stages two and three agree
  // a one-cycle glitch never reaches filt_q; a pin that keeps bouncing
  // leaves the last settled value in place
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q  <= '0;
    end else begin
      sync1_q <= {station_addr, status_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) filt_q <= sync3_q;
    end
  end

  // ==========================================================
  // sequencer next state
  // drain waits for the link to take the last word before going idle,
  // so busy covers the whole reply and no reading is gathered meanwhile;
  // an unknown state falls back to idle
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (take) st_d = ST_REPLY;
      end
      ST_REPLY: begin
        if (push && last) st_d = ST_DRAIN;
      end
      ST_DRAIN: begin
        if (fifo_empty) st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // change memory and common flag; a new change beats a clear
  // the clear only happens in drain and a change only while idle, but
  // the set is applied last so it would still win if both ever met
  always_comb begin
    chg_d = clr_chg ? '0 : chg_q;
    chg_d = chg_d | diff;
    cos_d = clr_chg ? 1'b0 : cos_q;
    if (diff != '0) begin
      cos_d = 1'b1;
    end
  end

  // ==========================================================
  // sequencer and request capture
  // the request fields stand for the whole reply and are only overwritten
  // by the next accepted request, so nothing stale is applied again;
  // msg_q counts the words pushed so far and ends the reply at total_q
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q        <= ST_IDLE;
      is_status_q <= 1'b0;
      sub_q       <= '0;
      start_q     <= '0;
      msg_q       <= CNT_RESET;
      total_q     <= CNT_RESET;
    end else begin
      st_q <= st_d;
      if (take) begin
        is_status_q <= want_stat;
        sub_q       <= rx_sub;
        start_q     <= IDX_W'(rx_start);
        msg_q       <= CNT_RESET;
        // data: 1..8 messages; status: header plus one per block
        total_q     <= want_stat ? CNT_W'(STATUS_BLOCKS) :
                       CNT_W'({1'b0, rx_count});
      end else if (push) begin
        msg_q <= msg_q + CNT_W'(1);
      end
    end
  end

  // ==========================================================
  // status store, current status written only while idle, change memory cleared in drain
  // a reply reads cur_q and chg_q while they are frozen, so all words of
  // one reply describe a single instant
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur_q <= '0;
      chg_q <= '0;
      cos_q <= 1'b0;
    end else begin
      if (idle) cur_q <= filt_sts;
      chg_q <= chg_d;
      cos_q <= cos_d;
    end
  end

  // data store, converter results taken only while idle
  // readings are refused while a reply runs, so a data reply never mixes
  // values from before and after a fresh conversion
  always_ff @(posedge clk) begin
    if (sample_valid && idle) begin
      data_q[sample_idx] <= sample_value;
    end
  end

  // ==========================================================
  // registered flags
  // acq_enable and busy follow the next state so they switch on the same
  // edge as the sequencer, with no cycle in which both are high;
  // check_error is a one-cycle pulse per received message whose check code disagrees
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acq_q     <= 1'b0;
      busy_q    <= 1'b0;
      chk_err_q <= 1'b0;
    end else begin
      acq_q     <= st_d == ST_IDLE;
      busy_q    <= st_d != ST_IDLE;
      chk_err_q <= rx_valid && !rx_chk_ok;
    end
  end

  // outputs, each straight from a flop
  assign acq_enable  = acq_q;
  assign busy        = busy_q;
  assign cos_flag    = cos_q;
  assign check_error = chk_err_q;

endmodule
`default_nettype wire

// >>> rtl/word_fifo.sv
// first-in first-out queue for outgoing reply messages
// assumes one clock; output stage is registered
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // queue and output stage both empty
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  wire              push;
  wire              load;

  // handshake decode
  assign in_ready  = cnt_q < (AW+1)'(DEPTH);
  assign push      = in_valid && in_ready;
  assign load      = (cnt_q != '0) && (!out_valid_q || out_ready);
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;
  assign empty     = (cnt_q == '0) && !out_valid_q;

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      if (load) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // registered output stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else if (load) begin
      out_valid_q <= 1'b1;
      out_data_q  <= mem_q[rd_q];
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> test/master_model.sv
// polling master on the far side of the message link
// assumes messages start just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module master_model
  import rtu_scan_pkg::*;
(
  // clock
  input wire logic                            clk,
  // requests out
  output logic                                rx_valid,
  output logic [rtu_scan_pkg::MSG_W-1:0]      rx_word,
  // replies in
  output logic                                tx_ready,
  input wire logic                            tx_valid,
  input wire logic [rtu_scan_pkg::MSG_W-1:0]  tx_word
);
  import rtu_scan_pkg::*;
  logic [MSG_W-1:0] got [$];
  bit               stall;
  bit               hold;
  int               cnt;

  initial begin
    rx_valid = 1'h0;
    rx_word = 32'h0;
    tx_ready = 1'h0;
  end

  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = CHK_INIT;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? CHK_POLY : 8'h00);
    return c;
  endfunction

  // one 32-bit request; a bad check bit on demand
  task automatic send(input logic [23:0] p, input bit bad);
    got.delete();
    rx_word = {crc8(p) ^ {7'h00, bad}, p};
    rx_valid = 1'h1;
    @(posedge clk);
    #1;
    rx_valid = 1'h0;
    rx_word = ~rx_word; // released line shows no stale value
    @(posedge clk);
    #1;
  endtask

  // collect replies, stall on demand
  always @(posedge clk) begin
    if (tx_valid === 1'h1 && tx_ready === 1'h1)
      got.push_back(tx_word);
    #1;
    cnt++;
    tx_ready = !hold && (!stall || cnt[1:0] == 2'h0);
  end
endmodule
`default_nettype wire

// >>> test/rtu_scan_responder_asserts.sv
// checker for the scan responder reply side
// assumes it is bound to every responder instance, one clock
`timescale 1ns/10ps
`default_nettype none
module rtu_scan_checker
  import rtu_scan_pkg::*;
(
  // clock and reset
  input wire logic                             clk,
  input wire logic                             reset,
  // station and link
  input wire logic [rtu_scan_pkg::ADDR_W-1:0]  station_addr,
  input wire logic                             rx_valid,
  input wire logic                             tx_valid,
  input wire logic                             tx_ready,
  input wire logic [rtu_scan_pkg::MSG_W-1:0]   tx_word,
  // station state
  input wire logic                             acq_enable,
  input wire logic                             cos_flag,
  input wire logic                             busy,
  input wire logic                             check_error
);
  import rtu_scan_pkg::*;

  // ==========================================================
  // check code of a sent message, msb first
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = CHK_INIT;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? CHK_POLY : 8'h00);
    return c;
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // reply behaviour
  busy_cause_a: assert property ($rose(busy) |-> $past(rx_valid))
    else $error("reply started without a request");
  idle_quiet_a: assert property (!busy |-> !tx_valid)
    else $error("message offered while idle");
  answer_time_a: assert property ($rose(busy) |-> ##2 tx_valid)
    else $error("first reply message late");
  acq_pause_a: assert property (busy |-> !acq_enable)
    else $error("acquisition open during reply");
  word_hold_a: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_word))
    else $error("reply message dropped or changed");
  check_code_a: assert property (tx_valid |->
      tx_word[31:24] == crc8(tx_word[23:0]))
    else $error("bad check code on reply");
  header_addr_a: assert property ($rose(busy) ##2 1'h1 |->
      tx_word[2:0] == station_addr && tx_word[8:6] == CLASS_READ)
    else $error("reply header address wrong");
  cos_mark_a: assert property (
      $rose(busy) ##2 (tx_word[11:9] != FC_STATUS_REPLY) |->
      tx_word[11:9] == (cos_flag ? FC_DATA_COS : FC_DATA))
    else $error("change mark wrong in header");
  flag_clear_a: assert property ($fell(cos_flag) |-> $past(busy))
    else $error("change flag cleared outside a reply");
  bad_check_a: assert property (check_error |-> $past(rx_valid))
    else $error("check error without a message");
endmodule

bind rtu_scan_responder rtu_scan_checker chk_i (
  .clk(clk), .reset(reset), .station_addr(station_addr),
  .rx_valid(rx_valid), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_word(tx_word), .acq_enable(acq_enable), .cos_flag(cos_flag),
  .busy(busy), .check_error(check_error));
`default_nettype wire

// >>> test/tb_rtu_scan_responder.sv
// self-checking bench for the scan responder and its queue
// assumes the checker is bound in and the master model drives the link
`timescale 1ns/10ps
`default_nettype none
module tb_rtu_scan_responder;
  import rtu_scan_pkg::*;
  logic        clk, reset, rx_valid, tx_valid, tx_ready, sample_valid;
  logic        acq_enable, cos_flag, busy, check_error;
  logic [2:0]  station_addr;
  logic [31:0] rx_word, tx_word, seed;
  logic [23:0] status_in, chg;
  logic [3:0]  sample_idx, st;
  logic [11:0] sample_value;
  logic [11:0] mem [16];
  int          mismatches, n_tests, cycles, n_err;

  rtu_scan_responder #(.DATA_WORDS(16), .STATUS_BLOCKS(2)) dut (
    .clk(clk), .reset(reset), .station_addr(station_addr),
    .rx_valid(rx_valid), .rx_word(rx_word), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_word(tx_word), .status_in(status_in),
    .sample_valid(sample_valid), .sample_idx(sample_idx),
    .sample_value(sample_value), .acq_enable(acq_enable),
    .cos_flag(cos_flag), .busy(busy), .check_error(check_error));
  master_model m (.clk(clk), .rx_valid(rx_valid), .rx_word(rx_word),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_word(tx_word));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // hang guard and check error counter
  always @(posedge clk) begin
    cycles++;
    if (check_error === 1'h1) n_err++;
    if (cycles == 30000) begin
      mismatches++;
      results();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic put(input logic [3:0] i, input logic [11:0] v, input bit u);
    sample_idx = i;
    sample_value = v;
    sample_valid = 1'h1;
    @(posedge clk);
    #1;
    sample_valid = 1'h0;
    if (u) mem[i] = v;
    @(posedge clk);
    #1;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    for (int i = 0; i < 200 && busy !== 1'h0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic req(input logic [2:0] a, input logic [2:0] fn,
                     input logic [3:0] s, input int n, input bit bad);
    m.send({5'h00, 3'(n - 1), s, fn, CLASS_READ, 3'h0, a}, bad);
    settle();
  endtask

  task automatic expect_data(input logic [3:0] s, input int n,
                             input logic [2:0] fn);
    logic [3:0] k;
    chk("reply count", n, m.got.size());
    if (m.got.size() == n) begin
      chk("header", {mem[s], fn, CLASS_READ, 6'h05}, m.got[0][23:0]);
      for (int j = 1; j < n; j++) begin
        k = s + 4'(2 * j);
        chk("data", {mem[k], mem[k - 4'h1]}, m.got[j][23:0]);
      end
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    seed = 32'h4E;
    {mismatches, n_tests, cycles, n_err} = '0;
    reset = 1'h1;
    station_addr = 3'h5;
    {status_in, chg, sample_valid, sample_idx, sample_value} = '0;
    repeat (8) @(posedge clk);
    #1;
    reset = 1'h0;
    @(posedge clk);
    #1;
    chk("acq after reset", 1'h1, acq_enable);
    chk("quiet after reset", 3'h0, {tx_valid, busy, cos_flag});
    repeat (5) @(posedge clk);
    #1;
    for (int i = 0; i < 16; i++) put(4'(i), 12'(rnd()), 1);
    // every reply length, wrap at the top, slow and quick master
    for (int n = 1; n <= 8; n++) begin
      st = (n == 8) ? 4'hF : 4'(rnd());
      m.stall = n[0];
      req(3'h5, FC_DATA, st, n, 0);
      expect_data(st, n, FC_DATA);
    end
    $display("test data_lengths done");
    // foreign and common addresses, bad check: no reply
    for (int a = 0; a < 8; a++) begin
      if (a != 5) req(3'(a), FC_DATA, 4'h0, 1, 0);
      chk("no reply", 0, m.got.size());
    end
    req(3'h5, FC_DATA, 4'h0, 1, 1);
    chk("bad check silent", 0, m.got.size());
    chk("bad check flagged", 1, n_err);
    $display("test refusals done");
    // request and sample while busy are both ignored
    m.send({5'h00, 3'h7, 4'h0, FC_DATA, CLASS_READ, 6'h05}, 0);
    m.send({5'h00, 3'h0, 4'h8, FC_DATA, CLASS_READ, 6'h05}, 0);
    put(4'h1, ~mem[1], 0);
    settle();
    expect_data(4'h0, 8, FC_DATA);
    $display("test busy_ignore done");
    // status change, momentary toggle, flagged reply, status collect
    chg = 24'(rnd()) | 24'h000001;
    status_in = chg;
    repeat (8) @(posedge clk);
    #1;
    status_in[0] = 1'h0;
    repeat (8) @(posedge clk);
    #1;
    chk("change flag", 1'h1, cos_flag);
    req(3'h5, FC_DATA, 4'h3, 2, 0);
    expect_data(4'h3, 2, FC_DATA_COS);
    chk("flag kept", 1'h1, cos_flag);
    req(3'h5, FC_STATUS, 4'h0, 1, 0);
    chk("status count", 3, m.got.size());
    if (m.got.size() == 3) begin
      chk("status header", {12'h002, FC_STATUS_REPLY, CLASS_READ, 6'h05},
          m.got[0][23:0]);
      for (int j = 0; j < 2; j++)
        chk("status block", {chg[12*j+:12], status_in[12*j+:12]},
            m.got[j+1][23:0]);
    end
    chk("flag cleared", 1'h0, cos_flag);
    req(3'h5, FC_DATA, 4'h3, 2, 0);
    expect_data(4'h3, 2, FC_DATA);
    $display("test change_report done");
    // queue: link held off for a whole reply, then drained with stalls
    m.hold = 1'h1;
    m.stall = 1'h1;
    m.send({5'h00, 3'h7, 4'h0, FC_DATA, CLASS_READ, 6'h05}, 0);
    repeat (20) @(posedge clk);
    #1;
    chk("queue holds", 2'h3, {busy, tx_valid});
    chk("queue head", {mem[0], FC_DATA, CLASS_READ, 6'h05},
        tx_word[23:0]);
    m.hold = 1'h0;
    settle();
    expect_data(4'h0, 8, FC_DATA);
    chk("queue drained", 1'h0, tx_valid);
    $display("test queue done");
    results();
  end
endmodule
`default_nettype wire
